// *** hw/dcgr_regs.v ***
// Notes on behaviour
// - Mode bit 0: manual or video, video default
// - Mode bit 4 fires manual trigger, self-clears
// - Mode bit 6 clears status word, self-clears
// - Mode bit 11 fires 3D snapshot, self-clears
// - Status 3,4,14 flag temperature sensor errors
// - Status 5 flags missing calibration data
// - Status 6 factory map loaded, reset 0040
// - Status 8 flags firmware fallback at start
// - Status 10 flags power budget limiting
// - Status 11 flags emitter module error
// - Status 13 flags colour stream failure
// - Status 15 flags sensor module failure
// - Format bits 3..10 select stream content
// - Exposure microseconds 1..1500, default 1500
// - Frequency in 10 kHz units, default 07d0
// - Firmware revision read-only, three fields
// - Serial number as two read-only words
// - Protected functions need matching password first
// - Lens angle identifier read and write
// - Status 9 over-temperature, illumination stopped
// - Sensor module error flag clears itself
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "dcgr_map.vh"
module dcgr_regs #(
   parameter [15:0] HW_IDENTITY = 16'h0a5a, // Arbitrary value
   parameter [15:0] FW_REVISION = 16'h0841,
   parameter [31:0] SERIAL = 32'h0000_0001
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Condition inputs from the camera, asynchronous
   input wire emit_temp_err,
   input wire sm_temp_err,
   input wire base_temp_err,
   input wire cal_missing,
   input wire factory_loaded,
   input wire fw_fallback,
   input wire over_temp,
   input wire poe_limited,
   input wire emit_err,
   input wire color_err,
   input wire sm_err,
   // Control outputs
   output reg video_mode,
   output reg manual_trigger,
   output reg snapshot_trigger,
   output reg illum_enable,
   output reg [7:0] output_format_sel,
   output reg [15:0] exposure_time_us,
   output reg [15:0] illum_freq,
   output reg [15:0] frame_rate_hz,
   output reg [15:0] lens_angle,
   output reg flash_unlocked,
   output reg test_unlocked
);

   localparam NCOND = 11;
   // Reset value of the stored format field, cut from the full register word
   localparam [15:0] RST_FORMAT_WORD = `DCGR_RST_FORMAT;
   localparam [7:0] RST_FORMAT_SEL = RST_FORMAT_WORD[`DCGR_FMT_MSB:`DCGR_FMT_LSB];

   // Register state
   reg [15:0] mode_control;
   reg [15:0] status_flags;
   reg [15:0] unlock_password;
   // Synchroniser stages and accepted condition levels
   reg [NCOND-1:0] sync1;
   reg [NCOND-1:0] sync2;
   reg [NCOND-1:0] sync3;
   reg [NCOND-1:0] cond;
   wire [NCOND-1:0] raw;
   // Bus decode
   wire addr_ok;
   wire wr_en;
   wire rd_en;
   wire [7:0] idx;
   wire full_word;
   wire wr_ok;
   wire wr_mode;
   wire wr_format;
   wire wr_exposure;
   wire wr_freq;
   wire wr_frate;
   wire wr_lens;
   wire wr_passwd;
   wire exp_in_range;
   // Read path and status helpers
   reg [15:0] rd_word;
   reg rd_hit;
   reg [15:0] set_mask;
   reg [15:0] level_mask;

   // Decode a word index as a mapped register
   function is_mapped;
      input [7:0] i;
      begin
         case (i)
            `DCGR_IDX_MODE, `DCGR_IDX_STATUS, `DCGR_IDX_FORMAT, `DCGR_IDX_EXPOSURE,
            `DCGR_IDX_HWID, `DCGR_IDX_FWREV, `DCGR_IDX_FREQ, `DCGR_IDX_FRATE,
            `DCGR_IDX_LENS, `DCGR_IDX_SER_LO, `DCGR_IDX_SER_HI,
            `DCGR_IDX_PASSWD: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Zero-wait slave; only aligned words of mapped registers are decoded,
   // everything else answers with an error and has no effect
   assign idx = paddr[9:2];
   assign pready = 1'b1;
   assign addr_ok = is_mapped(idx) & (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & addr_ok;
   // Read data is fetched in the setup cycle so that it stands at the access edge
   assign rd_en = psel & ~penable & ~pwrite;
   // Lower two strobes must both be set; a half write would tear a field
   assign full_word = pstrb[0] & pstrb[1];

   assign raw = {sm_err, base_temp_err, color_err, emit_err, poe_limited, over_temp,
                 fw_fallback, factory_loaded, cal_missing, sm_temp_err, emit_temp_err};

   // Three-stage synchronisers; change accepted when stages 2 and 3 agree
   genvar g;
   generate
      for (g = 0; g < NCOND; g = g + 1) begin : g_sync
         always @(posedge clk) begin
            if (!rst_b) begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
               sync3[g] <= 1'b0;
               cond[g] <= 1'b0;
            end else begin
               sync1[g] <= raw[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
               if (sync2[g] == sync3[g]) begin
                  cond[g] <= sync3[g];
               end
            end
         end
      end
   endgenerate

   // Map synchronised conditions onto status bit positions
   always @* begin
      set_mask = 16'h0000;
      set_mask[`DCGR_ST_EMIT_TEMP] = cond[0];
      set_mask[`DCGR_ST_SM_TEMP] = cond[1];
      set_mask[`DCGR_ST_BASE_TEMP] = cond[9];
      set_mask[`DCGR_ST_CAL] = cond[2];
      set_mask[`DCGR_ST_FACTORY] = cond[3];
      set_mask[`DCGR_ST_FWBACK] = cond[4];
      set_mask[`DCGR_ST_OVERTEMP] = cond[5];
      set_mask[`DCGR_ST_POE] = cond[6];
      set_mask[`DCGR_ST_EMIT_ERR] = cond[7];
      set_mask[`DCGR_ST_COLOR] = cond[8];
      set_mask[`DCGR_ST_SM_ERR] = cond[10];
      // Bits that follow their cause rather than stick
      level_mask = 16'h0000;
      level_mask[`DCGR_ST_EMIT_TEMP] = 1'b1;
      level_mask[`DCGR_ST_SM_TEMP] = 1'b1;
      level_mask[`DCGR_ST_OVERTEMP] = 1'b1;
      level_mask[`DCGR_ST_SM_ERR] = 1'b1;
   end

   // Status word: sticky flags except the level_mask bits, set wins over a clear command
   always @(posedge clk) begin
      if (!rst_b) begin
         status_flags <= `DCGR_RST_STATUS;
      end else if (mode_control[`DCGR_MODE_CLR]) begin
         status_flags <= set_mask;
      end else begin
         status_flags <= (status_flags & ~level_mask) | set_mask;
      end
   end

   // Write selects, one per writable word; a torn or refused access selects nothing
   assign wr_ok = wr_en & full_word;
   assign wr_mode = wr_ok & (idx == `DCGR_IDX_MODE);
   assign wr_format = wr_ok & (idx == `DCGR_IDX_FORMAT);
   assign wr_exposure = wr_ok & (idx == `DCGR_IDX_EXPOSURE);
   assign wr_freq = wr_ok & (idx == `DCGR_IDX_FREQ);
   assign wr_frate = wr_ok & (idx == `DCGR_IDX_FRATE);
   assign wr_lens = wr_ok & (idx == `DCGR_IDX_LENS);
   assign wr_passwd = wr_ok & (idx == `DCGR_IDX_PASSWD);
   assign exp_in_range = (pwdata[15:0] >= `DCGR_EXP_MIN) & (pwdata[15:0] <= `DCGR_EXP_MAX);

   // Mode control; bit 0 is a setting, the command bits live one cycle
   always @(posedge clk) begin
      if (!rst_b) begin
         mode_control <= `DCGR_RST_MODE;
      end else begin
         mode_control[`DCGR_MODE_TRIG] <= 1'b0;
         mode_control[`DCGR_MODE_CLR] <= 1'b0;
         mode_control[`DCGR_MODE_SNAP] <= 1'b0;
         if (wr_mode) begin
            mode_control[`DCGR_MODE_VIDEO] <= pwdata[`DCGR_MODE_VIDEO];
            mode_control[`DCGR_MODE_TRIG] <= pwdata[`DCGR_MODE_TRIG];
            mode_control[`DCGR_MODE_CLR] <= pwdata[`DCGR_MODE_CLR];
            mode_control[`DCGR_MODE_SNAP] <= pwdata[`DCGR_MODE_SNAP];
         end
      end
   end

   // Output format; only the eight-bit field is stored, the rest reads zero
   always @(posedge clk) begin
      if (!rst_b) begin
         output_format_sel <= RST_FORMAT_SEL;
      end else if (wr_format) begin
         output_format_sel <= pwdata[`DCGR_FMT_MSB:`DCGR_FMT_LSB];
      end
   end

   // Exposure; an out-of-range value is dropped whole rather than clamped,
   // so software finds its previous setting still in force
   always @(posedge clk) begin
      if (!rst_b) begin
         exposure_time_us <= `DCGR_RST_EXPOSURE;
      end else if (wr_exposure && exp_in_range) begin
         exposure_time_us <= pwdata[15:0];
      end
   end

   // Illumination frequency; rounding to a supported step is not done here
   always @(posedge clk) begin
      if (!rst_b) begin
         illum_freq <= `DCGR_RST_FREQ;
      end else if (wr_freq) begin
         illum_freq <= pwdata[15:0];
      end
   end

   // Frame rate; the power budget check sits outside this block
   always @(posedge clk) begin
      if (!rst_b) begin
         frame_rate_hz <= `DCGR_RST_FRATE;
      end else if (wr_frate) begin
         frame_rate_hz <= pwdata[15:0];
      end
   end

   // Lens angle identifier, kept for software only
   always @(posedge clk) begin
      if (!rst_b) begin
         lens_angle <= `DCGR_RST_LENS;
      end else if (wr_lens) begin
         lens_angle <= pwdata[15:0];
      end
   end

   // Unlock password; any value is stored, only the known ones unlock
   always @(posedge clk) begin
      if (!rst_b) begin
         unlock_password <= `DCGR_RST_PASSWD;
      end else if (wr_passwd) begin
         unlock_password <= pwdata[15:0];
      end
   end

   // Mode-derived outputs; each pulse lasts one cycle because the command
   // bit that it copies is cleared the cycle after the write
   always @(posedge clk) begin
      if (!rst_b) begin
         video_mode <= 1'b1;
         manual_trigger <= 1'b0;
         snapshot_trigger <= 1'b0;
      end else begin
         video_mode <= mode_control[`DCGR_MODE_VIDEO];
         manual_trigger <= mode_control[`DCGR_MODE_TRIG];
         snapshot_trigger <= mode_control[`DCGR_MODE_SNAP];
      end
   end

   // Illumination gate; off in reset, then on one cycle later unless cond[5] shows over-temperature
   always @(posedge clk) begin
      if (!rst_b) begin
         illum_enable <= 1'b0;
      end else begin
         illum_enable <= ~cond[5];
      end
   end

   // Unlock levels follow the password word, so any other value locks again
   always @(posedge clk) begin
      if (!rst_b) begin
         flash_unlocked <= 1'b0;
         test_unlocked <= 1'b0;
      end else begin
         flash_unlocked <= (unlock_password == `DCGR_PW_FLASH);
         test_unlocked <= (unlock_password == `DCGR_PW_TEST);
      end
   end

   // Read mux
   always @* begin
      rd_hit = 1'b1;
      case (idx)
         `DCGR_IDX_MODE: rd_word = mode_control;
         `DCGR_IDX_STATUS: rd_word = status_flags;
         `DCGR_IDX_FORMAT: rd_word = {5'h00, output_format_sel, 3'h0};
         `DCGR_IDX_EXPOSURE: rd_word = exposure_time_us;
         `DCGR_IDX_HWID: rd_word = HW_IDENTITY;
         `DCGR_IDX_FWREV: rd_word = FW_REVISION;
         `DCGR_IDX_FREQ: rd_word = illum_freq;
         `DCGR_IDX_FRATE: rd_word = frame_rate_hz;
         `DCGR_IDX_LENS: rd_word = lens_angle;
         `DCGR_IDX_SER_LO: rd_word = SERIAL[15:0];
         `DCGR_IDX_SER_HI: rd_word = SERIAL[31:16];
         `DCGR_IDX_PASSWD: rd_word = unlock_password;
         default: begin
            rd_word = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data is registered at setup; a refused address returns zero
   always @(posedge clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= (rd_hit && addr_ok) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

endmodule

// *** shared/dcgr_map.vh ***
`ifndef DCGR_MAP_VH
`define DCGR_MAP_VH
// Register indices; byte address is four times the index
`define DCGR_IDX_MODE 8'h01
`define DCGR_IDX_STATUS 8'h03
`define DCGR_IDX_FORMAT 8'h04
`define DCGR_IDX_EXPOSURE 8'h05
`define DCGR_IDX_HWID 8'h06
`define DCGR_IDX_FWREV 8'h08
`define DCGR_IDX_FREQ 8'h09
`define DCGR_IDX_FRATE 8'h0a
`define DCGR_IDX_LENS 8'h0b
`define DCGR_IDX_SER_LO 8'h0c
`define DCGR_IDX_SER_HI 8'h0d
`define DCGR_IDX_PASSWD 8'h22
// Mode control fields
`define DCGR_MODE_VIDEO 0
`define DCGR_MODE_TRIG 4
`define DCGR_MODE_CLR 6
`define DCGR_MODE_SNAP 11
// Status fields
`define DCGR_ST_EMIT_TEMP 3
`define DCGR_ST_SM_TEMP 4
`define DCGR_ST_CAL 5
`define DCGR_ST_FACTORY 6
`define DCGR_ST_FWBACK 8
`define DCGR_ST_OVERTEMP 9
`define DCGR_ST_POE 10
`define DCGR_ST_EMIT_ERR 11
`define DCGR_ST_COLOR 13
`define DCGR_ST_BASE_TEMP 14
`define DCGR_ST_SM_ERR 15
// Output format field
`define DCGR_FMT_LSB 3
`define DCGR_FMT_MSB 10
// Reset values
`define DCGR_RST_MODE 16'h0001
`define DCGR_RST_STATUS 16'h0040
`define DCGR_RST_FORMAT 16'h0000
`define DCGR_RST_EXPOSURE 16'h05dc
`define DCGR_RST_FREQ 16'h07d0
`define DCGR_RST_FRATE 16'h0028
`define DCGR_RST_LENS 16'h0000
`define DCGR_RST_PASSWD 16'h0000
// Exposure limits in microseconds
`define DCGR_EXP_MIN 16'h0001
`define DCGR_EXP_MAX 16'h05dc
// Unlock values
`define DCGR_PW_FLASH 16'h4877
`define DCGR_PW_TEST 16'h5e6b
`endif

// *** testbench/dcgr_regs_asserts.sv ***
`timescale 1ns/1ps
`include "dcgr_map.vh"
module dcgr_regs_asserts (
   // Clock, reset and bus
   input wire clk,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pslverr,
   // Camera side
   input wire over_temp,
   input wire video_mode,
   input wire manual_trigger,
   input wire snapshot_trigger,
   input wire illum_enable,
   input wire [15:0] exposure_time_us,
   input wire flash_unlocked,
   input wire test_unlocked
);
   // Accepted writes; partial strobes and errors change nothing
   wire wr = psel & penable & pwrite & ~pslverr & (&pstrb[1:0]);
   wire mw = wr && paddr[9:2] == `DCGR_IDX_MODE;
   wire pw = wr && paddr[9:2] == `DCGR_IDX_PASSWD;
   wire ew = wr && paddr[9:2] == `DCGR_IDX_EXPOSURE;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_trig_pulse: assert property (
      mw && pwdata[4] |=> ##1 manual_trigger ##1 !manual_trigger)
      else $error("manual trigger pulse wrong");
   a_snap_pulse: assert property (
      mw && pwdata[11] |=> ##1 snapshot_trigger ##1 !snapshot_trigger)
      else $error("snapshot pulse wrong");
   a_video_follow: assert property (
      mw |=> ##1 video_mode == $past(pwdata[0], 2))
      else $error("video mode not taken");
   a_exposure_refused: assert property (
      ew && (pwdata[15:0] == 0 || pwdata[15:0] > `DCGR_EXP_MAX)
      |=> $stable(exposure_time_us) [*2])
      else $error("exposure out of range accepted");
   a_illum_stop: assert property (
      over_temp [*8] |-> !illum_enable)
      else $error("illumination kept on when hot");
   a_illum_resume: assert property (
      !over_temp [*8] |-> illum_enable)
      else $error("illumination not restored");
   a_flash_unlock: assert property (
      pw && pwdata[15:0] == `DCGR_PW_FLASH |=> ##1 flash_unlocked && !test_unlocked)
      else $error("flash unlock wrong");
   a_test_locked: assert property (
      pw && pwdata[15:0] != `DCGR_PW_TEST |=> ##1 !test_unlocked)
      else $error("test unlocked without password");
   // Main scenarios reached
   c_trigger: cover property (mw && pwdata[4]);
   c_test_pw: cover property (pw && pwdata[15:0] == `DCGR_PW_TEST);
   c_hot: cover property (over_temp [*8]);
endmodule
bind dcgr_regs dcgr_regs_asserts u_chk (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
   .over_temp(over_temp), .video_mode(video_mode), .manual_trigger(manual_trigger),
   .snapshot_trigger(snapshot_trigger), .illum_enable(illum_enable),
   .exposure_time_us(exposure_time_us), .flash_unlocked(flash_unlocked),
   .test_unlocked(test_unlocked));

// *** testbench/tb_dcgr_regs.sv ***
`timescale 1ns/1ps
`include "dcgr_map.vh"
module tb_dcgr_regs;
   reg clk, rst_b, psel, penable, pwrite, er;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd;
   reg [3:0] pstrb;
   reg [10:0] cond;
   wire [31:0] prdata;
   wire pready, pslverr, video_mode, manual_trigger, snapshot_trigger, illum_enable;
   wire flash_unlocked, test_unlocked;
   wire [7:0] output_format_sel;
   wire [15:0] exposure_time_us, illum_freq, frame_rate_hz, lens_angle;
   integer err_count, compares, cyc, trig_n, snap_n, i;
   // Status bit raised by each condition input, in port order
   int pos[11] = '{3, 4, 14, 5, 6, 8, 9, 10, 11, 13, 15};
   int fmt[8] = '{0, 1, 3, 4, 9, 10, 12, 13};
   // Identity value is arbitrary
   dcgr_regs #(.HW_IDENTITY(16'h1234), .FW_REVISION(16'h28c7), .SERIAL(32'hbeef_0123)) dut (
      .emit_temp_err(cond[0]), .sm_temp_err(cond[1]), .base_temp_err(cond[2]),
      .cal_missing(cond[3]), .factory_loaded(cond[4]), .fw_fallback(cond[5]),
      .over_temp(cond[6]), .poe_limited(cond[7]), .emit_err(cond[8]),
      .color_err(cond[9]), .sm_err(cond[10]),
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .video_mode(video_mode), .manual_trigger(manual_trigger),
      .snapshot_trigger(snapshot_trigger), .illum_enable(illum_enable),
      .output_format_sel(output_format_sel), .exposure_time_us(exposure_time_us),
      .illum_freq(illum_freq), .frame_rate_hz(frame_rate_hz), .lens_angle(lens_angle),
      .flash_unlocked(flash_unlocked), .test_unlocked(test_unlocked));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // Pulse counts and the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (manual_trigger === 1'b1) trig_n <= trig_n + 1;
      if (snapshot_trigger === 1'b1) snap_n <= snap_n + 1;
      if (cyc == 5000) begin
         err_count = err_count + 1;
         report_and_stop;
      end
   end
   task report_and_stop;
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      compares = compares + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One APB transfer; held until pready is seen high
   task xfer(input w, input [11:0] a, input [15:0] d, input [3:0] s);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      // If pready never rises, only the bench timeout ends this wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input [7:0] x, input [15:0] d);
      xfer(1, {2'b00, x, 2'b00}, d, 4'hf);
   endtask
   task rc(input [7:0] x, input [31:0] e);
      xfer(0, {2'b00, x, 2'b00}, 16'h0000, 4'h0);
      chk(rd, e);
   endtask
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb, cond} = 0;
      {err_count, compares, cyc, trig_n, snap_n} = 0;
      repeat (2) @(posedge clk);
      rst_b <= 1;
      // Reset values, then read-only words ignore writes
      rc(`DCGR_IDX_MODE, 32'h1);
      rc(`DCGR_IDX_STATUS, 32'h40);
      rc(`DCGR_IDX_FORMAT, 32'h0);
      rc(`DCGR_IDX_FREQ, 32'h7d0);
      rc(`DCGR_IDX_FRATE, 32'h28);
      rc(`DCGR_IDX_HWID, 32'h1234);
      wr(`DCGR_IDX_FWREV, 16'hffff);
      wr(`DCGR_IDX_SER_LO, 16'hffff);
      wr(`DCGR_IDX_STATUS, 16'h0000);
      rc(`DCGR_IDX_FWREV, 32'h28c7);
      rc(`DCGR_IDX_SER_LO, 32'h0123);
      rc(`DCGR_IDX_SER_HI, 32'hbeef);
      rc(`DCGR_IDX_STATUS, 32'h40);
      for (i = 0; i < 8; i++) begin
         wr(`DCGR_IDX_FORMAT, fmt[i] << 3);
         rc(`DCGR_IDX_FORMAT, fmt[i] << 3);
         chk(output_format_sel, fmt[i]);
      end
      // Plain words, and a write with partial strobes that is dropped
      wr(`DCGR_IDX_FREQ, 16'h0c80);
      wr(`DCGR_IDX_FRATE, 16'h001e);
      wr(`DCGR_IDX_LENS, 16'h00a5);
      xfer(1, {2'b00, `DCGR_IDX_LENS, 2'b00}, 16'h5a5a, 4'h1);
      rc(`DCGR_IDX_LENS, 32'ha5);
      chk(illum_freq, 32'hc80);
      chk(lens_angle, 32'ha5);
      chk(frame_rate_hz, 32'h1e);
      // Exposure limits at both edges
      rc(`DCGR_IDX_EXPOSURE, 32'h5dc);
      wr(`DCGR_IDX_EXPOSURE, 16'h0001);
      wr(`DCGR_IDX_EXPOSURE, 16'h0000);
      rc(`DCGR_IDX_EXPOSURE, 32'h1);
      wr(`DCGR_IDX_EXPOSURE, 16'h05dd);
      chk(exposure_time_us, 32'h1);
      // Both triggers at once, manual mode kept
      wr(`DCGR_IDX_MODE, 16'h0810);
      rc(`DCGR_IDX_MODE, 32'h0);
      chk(video_mode, 0);
      chk(trig_n, 1);
      chk(snap_n, 1);
      // Each condition raises its own bit; some drop by themselves
      wr(`DCGR_IDX_MODE, 16'h0041);
      for (i = 0; i < 11; i++) begin
         cond <= 11'h001 << i;
         repeat (8) @(posedge clk);
         rc(`DCGR_IDX_STATUS, 1 << pos[i]);
         chk(illum_enable, pos[i] != 9);
         cond <= 11'h000;
         repeat (8) @(posedge clk);
         rc(`DCGR_IDX_STATUS, pos[i] inside {3, 4, 9, 15} ? 0 : 1 << pos[i]);
         wr(`DCGR_IDX_MODE, 16'h0041);
         rc(`DCGR_IDX_STATUS, 0);
      end
      // A condition still present survives a clear
      cond <= 11'h080;
      repeat (8) @(posedge clk);
      wr(`DCGR_IDX_MODE, 16'h0041);
      rc(`DCGR_IDX_STATUS, 32'h400);
      cond <= 11'h000;
      rc(`DCGR_IDX_MODE, 32'h1);
      chk(video_mode, 1);
      // Unlock values
      wr(`DCGR_IDX_PASSWD, `DCGR_PW_FLASH);
      rc(`DCGR_IDX_PASSWD, 32'h4877);
      chk(flash_unlocked, 1);
      wr(`DCGR_IDX_PASSWD, `DCGR_PW_TEST);
      rc(`DCGR_IDX_PASSWD, 32'h5e6b);
      chk({flash_unlocked, test_unlocked}, 1);
      // Unmapped and misaligned places
      xfer(0, 12'h008, 16'h0000, 4'h0);
      chk(er, 1);
      chk(rd, 0);
      xfer(1, 12'h005, 16'h0000, 4'hf);
      chk(er, 1);
      rc(`DCGR_IDX_MODE, 32'h1);
      report_and_stop;
   end
endmodule
